// [include/uec_pkg.sv]
package uec_pkg;
  localparam int ADDR_W = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DEV_ADDR = 8'h10;
  localparam logic [7:0] IDX_EP0_CNT = 8'h11;
  localparam logic [7:0] IDX_EP0_MODE = 8'h12;
  localparam logic [7:0] IDX_EP1_CNT = 8'h13;
  localparam logic [7:0] IDX_EP1_MODE = 8'h14;
  localparam logic [7:0] IDX_EP2_CNT = 8'h15;
  localparam logic [7:0] IDX_EP2_MODE = 8'h16;
  localparam logic [7:0] IDX_ENG_STAT = 8'h18;
  // buffer byte indices
  localparam logic [7:0] IDX_BUF_EP2 = 8'hE0;
  localparam logic [7:0] IDX_BUF_EP1 = 8'hF0;
  localparam logic [7:0] IDX_BUF_EP0 = 8'hF8;
  localparam logic [7:0] IDX_PROT_LO_A = 8'hE0;
  localparam logic [7:0] IDX_PROT_HI_A = 8'hE7;
  localparam logic [7:0] IDX_PROT_LO_B = 8'hF8;
  localparam logic [7:0] IDX_PROT_HI_B = 8'hFF;
  // field positions
  localparam int BIT_ADDR_EN = 7;
  localparam int BIT_SETUP = 7;
  localparam int BIT_IN = 6;
  localparam int BIT_OUT = 5;
  localparam int BIT_ACK = 4;
  localparam int BIT_TOGGLE = 7;
  localparam int BIT_DVALID = 6;
  localparam int BIT_BRST = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] MAX_COUNT = 4'h8;
  localparam int BUF_BYTES = 8;
  localparam int NUM_EP = 3;
  // bus reset timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SE0_MIN_NS = 8000;
  localparam int SE0_CYCLES = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    TOK_SETUP = 2'b00,
    TOK_IN = 2'b01,
    TOK_OUT = 2'b10,
    TOK_NONE = 2'b11
  } uec_tok_e;
  typedef enum logic [1:0] {
    RESP_IGNORE = 2'b00,
    RESP_ACK = 2'b01,
    RESP_NAK = 2'b10,
    RESP_STALL = 2'b11
  } uec_resp_e;
endpackage

// [logic/uec_se0_detect.sv]
`timescale 1ns/1ps
module uec_se0_detect #(
  parameter int CYCLES = uec_pkg::SE0_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic dp,
  input wire logic dm,
  output logic bus_reset_pulse
);
  import uec_pkg::*;
  localparam int CW = $clog2(CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
  logic [CW-1:0] cnt_r;
  logic fired_r;
  logic se0;
  assign se0 = !dp && !dm;
  // count saturates; fired flag keeps one long reset to one pulse
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (!se0) begin
      cnt_r <= '0;
    end else if (cnt_r <= LIMIT) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fired_r <= 1'b0;
      bus_reset_pulse <= 1'b0;
    end else begin
      bus_reset_pulse <= 1'b0;
      if (!se0) begin
        fired_r <= 1'b0;
      end else if (cnt_r > LIMIT && !fired_r) begin
        fired_r <= 1'b1;
        bus_reset_pulse <= 1'b1;
      end
    end
  end
endmodule

// [logic/uec_endpoint_ctrl.sv]
`timescale 1ns/1ps
// Operation
// - address cleared by reset and bus reset
// - no traffic accepted until address enabled
// - three endpoints, eight-byte buffer each
// - control endpoint handles setup, in, out
// - all mode registers clear on reset
// - control mode bits 7:5 sticky token flags
// - data endpoint mode bits 7:5 reserved
// - ack bit set on acked transaction
// - setup flag forced, clear blocked until read
// - engine update locks control mode bits 6:0 until read
// - setup flag blocks writes to protected buffers
// - mode bits select endpoint response
// - byte count zero to eight only
// - data valid only for out and setup
// - toggle bit selects DATA0 or DATA1
// - long SE0 flags bus reset, no cpu reset
// - per-endpoint event after each packet
module uec_endpoint_ctrl #(
  parameter logic [95:0] MODE_LUT = {16{6'b10_10_10}},
  parameter int SE0_CNT = uec_pkg::SE0_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic se_tok_valid,
  input wire logic [1:0] se_tok_pid,
  input wire logic [6:0] se_tok_addr,
  input wire logic [1:0] se_tok_ep,
  output logic se_resp_valid,
  output logic [1:0] se_resp_code,
  input wire logic se_setup_data_start,
  input wire logic se_ack_start,
  input wire logic se_done,
  input wire logic se_done_ack,
  input wire logic [1:0] se_done_ep,
  input wire logic [1:0] se_done_pid,
  input wire logic [3:0] se_rx_count,
  input wire logic se_buf_we,
  input wire logic [1:0] se_buf_ep,
  input wire logic [2:0] se_buf_idx,
  input wire logic [7:0] se_buf_wdata,
  output logic [7:0] se_buf_rdata,
  output logic [3:0] se_tx_count,
  output logic se_tx_toggle,
  output logic [2:0] ep_event,
  output logic bus_reset_event
);
  import uec_pkg::*;

  logic [7:0] dev_addr_r;
  logic [7:0] cnt_r [0:NUM_EP-1];
  logic [7:0] mode_r [0:NUM_EP-1];
  logic [7:0] buf_r [0:NUM_EP*BUF_BYTES-1];
  logic setup_force_r;
  logic setup_prot_r;
  logic ep0_lock_r;
  logic brst_flag_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_full_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_full_r;
  logic brst_pulse;
  logic do_wr;
  logic do_rd;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic wr_hit;
  logic wr_ok;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic rd_hit;
  logic rd_ep0_mode;
  logic se_buf_hit;
  logic [5:0] wslot;
  logic [5:0] rslot;

  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // buffer slot: {valid, ep, byte}
  function automatic logic [5:0] buf_slot(input logic [7:0] idx);
    logic [5:0] s;
    s = '0;
    if (idx[7:3] == IDX_BUF_EP0[7:3]) begin
      s = {1'b1, 2'd0, idx[2:0]};
    end else if (idx[7:3] == IDX_BUF_EP1[7:3]) begin
      s = {1'b1, 2'd1, idx[2:0]};
    end else if (idx[7:3] == IDX_BUF_EP2[7:3]) begin
      s = {1'b1, 2'd2, idx[2:0]};
    end
    return s;
  endfunction

  function automatic logic [4:0] buf_addr(input logic [1:0] ep, input logic [2:0] b);
    return 5'({ep, 3'b000}) + 5'(b);
  endfunction

  function automatic logic [3:0] clamp_cnt(input logic [3:0] c);
    return (c > MAX_COUNT) ? MAX_COUNT : c;
  endfunction

  uec_se0_detect #(
    .CYCLES(SE0_CNT)
  ) u_se0 (
    .mclk(mclk),
    .resetn(resetn),
    .dp(usb_dp),
    .dm(usb_dm),
    .bus_reset_pulse(brst_pulse)
  );

  // axi write channel capture, either order
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign do_wr = aw_full_r && w_full_r && !s_axi_bvalid;
  assign widx = word_idx(awaddr_r);
  assign wslot = buf_slot(widx);
  assign wbyte = wstrb_r[0] ? wdata_r[7:0] : 8'h00;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      w_full_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_r <= 1'b0;
    end
  end

  // write decode; protected buffer writes are dropped but answered okay
  always_comb begin
    wr_hit = 1'b0;
    wr_ok = 1'b0;
    if (widx >= IDX_DEV_ADDR && widx <= IDX_EP2_MODE) begin
      wr_hit = 1'b1;
      wr_ok = 1'b1;
    end else if (widx == IDX_ENG_STAT) begin
      wr_hit = 1'b1;
      wr_ok = 1'b1;
    end else if (wslot[5]) begin
      wr_hit = 1'b1;
      wr_ok = !(mode_r[0][BIT_SETUP] &&
        ((widx >= IDX_PROT_LO_A && widx <= IDX_PROT_HI_A) ||
         (widx >= IDX_PROT_LO_B && widx <= IDX_PROT_HI_B)));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign ridx = word_idx(s_axi_araddr);
  assign rslot = buf_slot(ridx);
  assign rd_ep0_mode = do_rd && (ridx == IDX_EP0_MODE);

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (ridx == IDX_DEV_ADDR) begin
      rd_val = dev_addr_r;
    end else if (ridx == IDX_EP0_CNT) begin
      rd_val = cnt_r[0];
    end else if (ridx == IDX_EP0_MODE) begin
      rd_val = mode_r[0];
    end else if (ridx == IDX_EP1_CNT) begin
      rd_val = cnt_r[1];
    end else if (ridx == IDX_EP1_MODE) begin
      rd_val = mode_r[1];
    end else if (ridx == IDX_EP2_CNT) begin
      rd_val = cnt_r[2];
    end else if (ridx == IDX_EP2_MODE) begin
      rd_val = mode_r[2];
    end else if (ridx == IDX_ENG_STAT) begin
      rd_val = {7'h00, brst_flag_r};
    end else if (rslot[5]) begin
      rd_val = buf_r[buf_addr(rslot[4:3], rslot[2:0])];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // device address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dev_addr_r <= RST_REG;
    end else if (brst_pulse) begin
      dev_addr_r <= RST_REG;
    end else if (do_wr && widx == IDX_DEV_ADDR && wstrb_r[0]) begin
      dev_addr_r <= wbyte;
    end
  end

  // setup flag hold window and clear protection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      setup_force_r <= 1'b0;
    end else if (se_setup_data_start) begin
      setup_force_r <= 1'b1;
    end else if (se_ack_start) begin
      setup_force_r <= 1'b0;
    end
  end

  // protection outlives the window until the first control mode read that follows it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      setup_prot_r <= 1'b0;
    end else if (se_setup_data_start) begin
      setup_prot_r <= 1'b1;
    end else if (rd_ep0_mode && !setup_force_r) begin
      setup_prot_r <= 1'b0;
    end
  end

  // engine update locks cpu writes to control mode bits 6:0 until a control mode read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ep0_lock_r <= 1'b0;
    end else if (se_done && se_done_ep == 2'd0) begin
      ep0_lock_r <= 1'b1;
    end else if (rd_ep0_mode) begin
      ep0_lock_r <= 1'b0;
    end
  end

  // mode registers; engine sets win over cpu writes in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_EP; i++) begin
        mode_r[i] <= RST_REG;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (do_wr && wstrb_r[0] && widx == IDX_EP0_MODE + 8'(2 * i)) begin
          if (i != 0) begin
            mode_r[i] <= {3'b000, wbyte[4:0]};
          end else begin
            if (!ep0_lock_r) begin
              mode_r[i][6:0] <= wbyte[6:0];
            end
            // lock covers bits 6:0 only; bit 7 has its own guard
            if (!setup_prot_r) begin
              mode_r[i][BIT_SETUP] <= wbyte[7];
            end
          end
        end
        if (se_done && se_done_ep == 2'(i)) begin
          if (se_done_ack) begin
            mode_r[i][BIT_ACK] <= 1'b1;
          end
          if (i == 0) begin
            case (se_done_pid)
              TOK_SETUP: mode_r[i][BIT_SETUP] <= 1'b1;
              TOK_IN: mode_r[i][BIT_IN] <= 1'b1;
              TOK_OUT: mode_r[i][BIT_OUT] <= 1'b1;
              default: ;
            endcase
          end
        end
        if (i == 0 && setup_force_r) begin
          mode_r[i][BIT_SETUP] <= 1'b1;
        end
      end
    end
  end

  // counter registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_EP; i++) begin
        cnt_r[i] <= RST_REG;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (do_wr && wstrb_r[0] && widx == IDX_EP0_CNT + 8'(2 * i)) begin
          // out-of-range counts saturate so the engine never overruns
          cnt_r[i] <= {wbyte[7:6], 2'b00, clamp_cnt(wbyte[3:0])};
        end
        if (se_done && se_done_ep == 2'(i) && se_done_pid != TOK_IN) begin
          cnt_r[i][BIT_DVALID] <= se_done_ack;
          cnt_r[i][3:0] <= clamp_cnt(se_rx_count);
        end
      end
    end
  end

  // endpoint buffers; engine port has priority over the bus
  assign se_buf_hit = se_buf_we && se_buf_ep < 2'(NUM_EP);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_EP * BUF_BYTES; i++) begin
        buf_r[i] <= RST_REG;
      end
    end else begin
      if (do_wr && wr_ok && wstrb_r[0] && wslot[5]) begin
        buf_r[buf_addr(wslot[4:3], wslot[2:0])] <= wbyte;
      end
      if (se_buf_hit) begin
        buf_r[buf_addr(se_buf_ep, se_buf_idx)] <= se_buf_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      se_buf_rdata <= 8'h00;
    end else if (se_buf_ep < 2'(NUM_EP)) begin
      se_buf_rdata <= buf_r[buf_addr(se_buf_ep, se_buf_idx)];
    end
  end

  // token answer from address check and mode lookup
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      se_resp_valid <= 1'b0;
      se_resp_code <= RESP_IGNORE;
      se_tx_count <= 4'h0;
      se_tx_toggle <= 1'b0;
    end else begin
      se_resp_valid <= se_tok_valid;
      se_resp_code <= RESP_IGNORE;
      if (se_tok_valid && dev_addr_r[BIT_ADDR_EN] && se_tok_addr == dev_addr_r[6:0] &&
          se_tok_ep < 2'(NUM_EP) && se_tok_pid != TOK_NONE) begin
        se_resp_code <= MODE_LUT[6 * mode_r[se_tok_ep][3:0] + 2 * se_tok_pid +: 2];
        se_tx_count <= clamp_cnt(cnt_r[se_tok_ep][3:0]);
        se_tx_toggle <= cnt_r[se_tok_ep][BIT_TOGGLE];
      end
    end
  end

  // events and bus reset status; set wins over clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ep_event <= 3'b000;
      bus_reset_event <= 1'b0;
      brst_flag_r <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_event[i] <= se_done && se_done_ep == 2'(i);
      end
      bus_reset_event <= brst_pulse;
      if (brst_pulse) begin
        brst_flag_r <= 1'b1;
      end else if (do_wr && widx == IDX_ENG_STAT && wstrb_r[0] && wbyte[BIT_BRST]) begin
        brst_flag_r <= 1'b0;
      end
    end
  end
endmodule

// [verification/uec_endpoint_ctrl_asserts.sv]
`timescale 1ns/1ps
module uec_endpoint_ctrl_asserts #(
  parameter int SE0_CNT = 160
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic se_tok_valid,
  input wire logic [1:0] se_tok_pid,
  input wire logic [1:0] se_tok_ep,
  input wire logic se_resp_valid,
  input wire logic [1:0] se_resp_code,
  input wire logic se_done,
  input wire logic [1:0] se_done_ep,
  input wire logic [3:0] se_tx_count,
  input wire logic [2:0] ep_event,
  input wire logic bus_reset_event
);
  logic [9:0] se0_r;
  logic [3:0] since_r;
  // saturating, so a stuck line cannot wrap into a false short episode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      se0_r <= 10'h000;
    end else if (usb_dp || usb_dm) begin
      se0_r <= 10'h000;
    end else if (se0_r != 10'h3ff) begin
      se0_r <= se0_r + 10'h001;
    end
  end
  // cycles since the line was last seen long enough in SE0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      since_r <= 4'hf;
    end else if (int'(se0_r) > SE0_CNT) begin
      since_r <= 4'h0;
    end else if (since_r != 4'hf) begin
      since_r <= since_r + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence tok_s; se_tok_valid; endsequence
  sequence brst_s; bus_reset_event; endsequence
  resp_lat_a: assert property (tok_s |=> se_resp_valid)
    else $error("no response one cycle after token");
  resp_cause_a: assert property (se_resp_valid |-> $past(se_tok_valid))
    else $error("response without token");
  bad_tok_a: assert property (se_tok_valid && (se_tok_pid == 2'b11 || se_tok_ep == 2'b11)
    |=> se_resp_code == 2'b00) else $error("answer to unusable token");
  cnt_max_a: assert property (se_tx_count <= 4'h8)
    else $error("byte count above eight");
  ep_evt_a: assert property (se_done && se_done_ep != 2'b11
    |=> (ep_event & (3'b001 << $past(se_done_ep))) != 3'b000) else $error("event missing");
  evt_cause_a: assert property (ep_event != 3'b000 |-> $past(se_done))
    else $error("event without done");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  brst_cause_a: assert property (brst_s |-> since_r < 4'h8)
    else $error("bus reset without long SE0");
  brst_once_a: assert property (brst_s |=> !bus_reset_event [*4])
    else $error("bus reset repeated");
endmodule
bind uec_endpoint_ctrl uec_endpoint_ctrl_asserts #(.SE0_CNT(SE0_CNT)) u_chk (.*);

// [verification/uec_engine_model.sv]
`timescale 1ns/1ps
module uec_engine_model (
  input wire logic mclk,
  input wire logic se_resp_valid,
  input wire logic [1:0] se_resp_code,
  output logic usb_dp,
  output logic usb_dm,
  output logic se_tok_valid,
  output logic [1:0] se_tok_pid,
  output logic [6:0] se_tok_addr,
  output logic [1:0] se_tok_ep,
  output logic se_setup_data_start,
  output logic se_ack_start,
  output logic se_done,
  output logic se_done_ack,
  output logic [1:0] se_done_ep,
  output logic [1:0] se_done_pid,
  output logic [3:0] se_rx_count,
  output logic se_buf_we,
  output logic [1:0] se_buf_ep,
  output logic [2:0] se_buf_idx,
  output logic [7:0] se_buf_wdata
);
  // idle line is the low-speed J state
  initial begin
    {usb_dp, usb_dm} = 2'b01;
    {se_tok_valid, se_tok_pid, se_tok_addr, se_tok_ep} = 12'h000;
    {se_setup_data_start, se_ack_start, se_done, se_done_ack} = 4'h0;
    {se_done_ep, se_done_pid, se_rx_count} = 8'h00;
    {se_buf_we, se_buf_ep, se_buf_idx, se_buf_wdata} = 14'h0000;
  end
  // payload inverted once the strobe drops, so stale fields never look valid
  task automatic tok(input logic [1:0] pid, input logic [6:0] a, input logic [1:0] ep,
                     output logic [1:0] code, output logic v);
    @(posedge mclk);
    {se_tok_valid, se_tok_pid, se_tok_addr, se_tok_ep} <= {1'b1, pid, a, ep};
    @(posedge mclk);
    {se_tok_valid, se_tok_pid, se_tok_addr, se_tok_ep} <= {1'b0, ~pid, ~a, ~ep};
    #1;
    code = se_resp_code;
    v = se_resp_valid;
  endtask
  task automatic done(input logic ack, input logic [1:0] ep, input logic [1:0] pid,
                      input logic [3:0] n);
    @(posedge mclk);
    {se_done, se_done_ack, se_done_ep, se_done_pid, se_rx_count} <= {1'b1, ack, ep, pid, n};
    @(posedge mclk);
    {se_done, se_done_ack, se_done_ep, se_done_pid, se_rx_count} <= {1'b0, ~ack, ~ep, ~pid, ~n};
  endtask
  task automatic mark(input logic ack);
    @(posedge mclk);
    if (ack) se_ack_start <= 1'b1;
    else se_setup_data_start <= 1'b1;
    @(posedge mclk);
    se_ack_start <= 1'b0;
    se_setup_data_start <= 1'b0;
  endtask
  task automatic se0(input int n);
    @(posedge mclk);
    {usb_dp, usb_dm} <= 2'b00;
    repeat (n) @(posedge mclk);
    usb_dm <= 1'b1;
  endtask
  // address is left standing so the read port keeps showing the byte
  task automatic bw(input logic [1:0] ep, input logic [2:0] idx, input logic [7:0] d);
    @(posedge mclk);
    {se_buf_we, se_buf_ep, se_buf_idx, se_buf_wdata} <= {1'b1, ep, idx, d};
    @(posedge mclk);
    se_buf_we <= 1'b0;
  endtask
endmodule

// [verification/uec_endpoint_ctrl_tb.sv]
`timescale 1ns/1ps
module uec_endpoint_ctrl_tb;
  import uec_pkg::*;
  localparam int SE0_SHORT = 8;
  // only mode 15 differs: out ack, in stall, setup ignore
  localparam logic [95:0] TB_LUT = {6'b01_11_00, {15{6'b10_10_10}}};
  logic mclk, resetn, brst_seen, seen_clr;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, se_rx_count, se_tx_count;
  logic [1:0] s_axi_bresp, s_axi_rresp, se_tok_pid, se_tok_ep, se_resp_code;
  logic [1:0] se_done_ep, se_done_pid, se_buf_ep;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic usb_dp, usb_dm, se_tok_valid, se_resp_valid, se_setup_data_start;
  logic se_ack_start, se_done, se_done_ack, se_buf_we, se_tx_toggle, bus_reset_event;
  logic [6:0] se_tok_addr;
  logic [2:0] se_buf_idx, ep_event, evt_seen;
  logic [7:0] se_buf_wdata, se_buf_rdata;
  int num_errors, n_tests;
  uec_endpoint_ctrl #(.MODE_LUT(TB_LUT), .SE0_CNT(SE0_SHORT)) u_dut (.*);
  uec_engine_model u_eng (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (seen_clr) begin
      evt_seen <= 3'h0;
      brst_seen <= 1'b0;
    end else begin
      evt_seen <= evt_seen | ep_event;
      brst_seen <= brst_seen | bus_reset_event;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    logic b;
    logic [1:0] r;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= {idx, 2'b00, 1'b1, d, 1'b1};
    s_axi_bready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (!b && n < 100) begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      b = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    chk({29'h0, b, r}, {29'h0, 1'b1, AXI_OKAY});
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {idx, 2'b00, 1'b1, 1'b1};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, e);
  endtask
  task automatic tk(input logic [1:0] pid, input logic [6:0] a, input logic [1:0] ep,
                    input logic [1:0] e);
    logic [1:0] c;
    logic v;
    u_eng.tok(pid, a, ep, c, v);
    chk({29'h0, v, c}, {29'h0, 1'b1, e});
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(4000 * 50);
    num_errors++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    resetn = 1'b0;
    seen_clr = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0_0000_0000_0000;
    s_axi_wstrb = 4'hf;
    num_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    seen_clr <= 1'b0;
    for (int i = 0; i < 7; i++) rc(IDX_DEV_ADDR + 8'(i), 32'h0000_0000);
    rd(8'h17, d, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    chk(d, 32'h0000_0000);
    tk(TOK_SETUP, 7'h00, 2'h0, RESP_IGNORE);
    wr(IDX_DEV_ADDR, 32'h0000_0085);
    rc(IDX_DEV_ADDR, 32'h0000_0085);
    wr(IDX_EP1_CNT, 32'h0000_0085);
    tk(TOK_IN, 7'h05, 2'h1, RESP_NAK);
    chk({27'h0, se_tx_toggle, se_tx_count}, 32'h0000_0015);
    tk(TOK_SETUP, 7'h05, 2'h0, RESP_NAK);
    tk(TOK_OUT, 7'h06, 2'h1, RESP_IGNORE);
    tk(TOK_NONE, 7'h05, 2'h0, RESP_IGNORE);
    tk(TOK_OUT, 7'h05, 2'h3, RESP_IGNORE);
    wr(IDX_EP1_CNT, 32'h0000_000f);
    rc(IDX_EP1_CNT, 32'h0000_0008);
    wr(IDX_EP1_MODE, 32'h0000_00ff);
    rc(IDX_EP1_MODE, 32'h0000_001f);
    tk(TOK_IN, 7'h05, 2'h1, RESP_STALL);
    tk(TOK_OUT, 7'h05, 2'h1, RESP_ACK);
    tk(TOK_SETUP, 7'h05, 2'h1, RESP_IGNORE);
    seen_clr <= 1'b1;
    @(posedge mclk);
    seen_clr <= 1'b0;
    u_eng.done(1'b1, 2'h0, TOK_OUT, 4'h3);
    wr(IDX_EP0_MODE, 32'h0000_0000);
    rc(IDX_EP0_MODE, 32'h0000_0030);
    rc(IDX_EP0_CNT, 32'h0000_0043);
    wr(IDX_EP0_MODE, 32'h0000_0000);
    rc(IDX_EP0_MODE, 32'h0000_0000);
    u_eng.done(1'b1, 2'h2, TOK_IN, 4'h5);
    rc(IDX_EP2_MODE, 32'h0000_0010);
    rc(IDX_EP2_CNT, 32'h0000_0000);
    chk({29'h0, evt_seen}, 32'h0000_0005);
    u_eng.mark(1'b0);
    wr(IDX_EP0_MODE, 32'h0000_0000);
    rc(IDX_EP0_MODE, 32'h0000_0080);
    wr(IDX_PROT_LO_A, 32'h0000_00aa);
    rc(IDX_PROT_LO_A, 32'h0000_0000);
    wr(IDX_PROT_HI_B, 32'h0000_00aa);
    rc(IDX_PROT_HI_B, 32'h0000_0000);
    wr(IDX_BUF_EP1, 32'h0000_0055);
    rc(IDX_BUF_EP1, 32'h0000_0055);
    u_eng.bw(2'h1, 3'h1, 8'h3c);
    @(posedge mclk);
    #1;
    chk({24'h0, se_buf_rdata}, 32'h0000_003c);
    rc(IDX_BUF_EP1 + 8'h01, 32'h0000_003c);
    u_eng.mark(1'b1);
    rc(IDX_EP0_MODE, 32'h0000_0080);
    wr(IDX_EP0_MODE, 32'h0000_0000);
    rc(IDX_EP0_MODE, 32'h0000_0000);
    wr(IDX_PROT_LO_A, 32'h0000_00aa);
    rc(IDX_PROT_LO_A, 32'h0000_00aa);
    u_eng.se0(SE0_SHORT - 4);
    repeat (8) @(posedge mclk);
    chk({31'h0, brst_seen}, 32'h0000_0000);
    u_eng.se0(SE0_SHORT + 12);
    repeat (8) @(posedge mclk);
    chk({31'h0, brst_seen}, 32'h0000_0001);
    rc(IDX_DEV_ADDR, 32'h0000_0000);
    rc(IDX_ENG_STAT, 32'h0000_0001);
    wr(IDX_ENG_STAT, 32'h0000_0001);
    rc(IDX_ENG_STAT, 32'h0000_0000);
    rc(IDX_EP1_MODE, 32'h0000_001f);
    tk(TOK_SETUP, 7'h00, 2'h0, RESP_IGNORE);
    summarize();
  end
endmodule
